// ===== rtl/prcs_ctl.sv
// fabric controller for the switchover circuit, avalon-mm registers
`timescale 1ns/1ns
`include "prcs_regs.svh"
module prcs_ctl
    import prcs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    prcs_if.ctl lnk,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    output logic pll_areset,
    output logic pfd_enable,
    output logic clk_out_enable
);

    logic [31:0] ctrl;
    logic [`PRCS_IRQ_W-1:0] irq_stat;
    logic [`PRCS_IRQ_W-1:0] irq_en;
    logic [`PRCS_IRQ_W-1:0] ev;
    logic [`PRCS_IRQ_W-1:0] st_q;
    logic [`PRCS_IRQ_W-1:0] st_now;
    logic req_pend;
    logic acc;
    logic [7:0] tmr;
    prcs_ctl_state_e cstate;

    function automatic logic hit(input logic [4:0] a, input logic [4:0] r);
        hit = (a == r);
    endfunction

    assign acc = (avs_read | avs_write) & ~avs_waitrequest;
    assign st_now = {lnk.lock_seen, lnk.active_sel, lnk.switch_cond,
        lnk.ref_b_dead_flag, lnk.ref_a_dead_flag};
    // rising edges of each status line, plus any change of selection
    assign ev = (st_now & ~st_q) |
        {1'b0, lnk.active_sel ^ st_q[`PRCS_ST_SEL], 3'h0};

    // one wait cycle per access keeps the decode registered
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
            avs_readdata <= 32'h0000_0000;
            if (avs_read & avs_waitrequest) begin
                if (hit(avs_address, `PRCS_ADDR_CTRL)) begin
                    avs_readdata <= ctrl | {31'h0, req_pend};
                end else if (hit(avs_address, `PRCS_ADDR_STATUS)) begin
                    avs_readdata <= {25'h0, pfd_enable, clk_out_enable,
                        st_now};
                end else if (hit(avs_address, `PRCS_ADDR_IRQ_STAT)) begin
                    avs_readdata <= {27'h0, irq_stat};
                end else if (hit(avs_address, `PRCS_ADDR_IRQ_EN)) begin
                    avs_readdata <= {27'h0, irq_en};
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= `PRCS_CTRL_RESET;
            irq_en <= '0;
        end else if (avs_write & acc) begin
            if (hit(avs_address, `PRCS_ADDR_CTRL)) begin
                ctrl <= avs_writedata & ~32'h0000_0001;
            end else if (hit(avs_address, `PRCS_ADDR_IRQ_EN)) begin
                irq_en <= avs_writedata[`PRCS_IRQ_W-1:0];
            end
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat <= '0;
            st_q <= '0;
            irq <= 1'b0;
        end else begin
            st_q <= st_now;
            if (avs_write & acc & hit(avs_address, `PRCS_ADDR_IRQ_CLR)) begin
                irq_stat <= (irq_stat & ~avs_writedata[`PRCS_IRQ_W-1:0]) | ev;
            end else begin
                irq_stat <= irq_stat | ev;
            end
            irq <= |(irq_stat & irq_en);
        end
    end

    // request bit: level in manual mode, held pulse in automatic mode
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            req_pend <= 1'b0;
            lnk.switch_req <= 1'b0;
            lnk.auto_mode <= 1'b0;
            lnk.delay_sel <= '0;
        end else begin
            lnk.auto_mode <= ctrl[`PRCS_CTRL_AUTO];
            lnk.delay_sel <= ctrl[`PRCS_CTRL_DLY_HI:`PRCS_CTRL_DLY_LO];
            if (avs_write & acc & hit(avs_address, `PRCS_ADDR_CTRL)) begin
                req_pend <= avs_writedata[`PRCS_CTRL_REQ];
            end else if (ctrl[`PRCS_CTRL_AUTO] && ev[`PRCS_ST_SEL]) begin
                req_pend <= 1'b0;
            end
            lnk.switch_req <= req_pend;
        end
    end

    // detector off while an input is dead
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pfd_enable <= 1'b1;
        end else begin
            pfd_enable <= ~(ctrl[`PRCS_CTRL_PFD_AUTO] &
                (lnk.ref_a_dead_flag | lnk.ref_b_dead_flag));
        end
    end

    // reset pulse after a switch, then gates shut until lock settles
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cstate <= CT_RUN;
            tmr <= 8'h00;
            pll_areset <= 1'b0;
            clk_out_enable <= 1'b1;
        end else begin
            unique case (cstate)
                CT_RUN: begin
                    if (lnk.switch_cond) begin
                        clk_out_enable <= 1'b0;
                    end
                    if (ev[`PRCS_ST_SEL] && ctrl[`PRCS_CTRL_PHASE]) begin
                        pll_areset <= 1'b1;
                        tmr <= 8'(`PRCS_ARESET_CYC);
                        clk_out_enable <= 1'b0;
                        cstate <= CT_RESET;
                    end else if (!clk_out_enable || ev[`PRCS_ST_SEL]) begin
                        tmr <= 8'h00;
                        clk_out_enable <= 1'b0;
                        cstate <= CT_WAIT_LOCK;
                    end
                end
                CT_RESET: begin
                    if (tmr == 8'h01) begin
                        pll_areset <= 1'b0;
                        tmr <= 8'h00;
                        cstate <= CT_WAIT_LOCK;
                    end else begin
                        tmr <= tmr - 8'h01;
                    end
                end
                CT_WAIT_LOCK: begin
                    // switch lands while the gates are already shut
                    if (ev[`PRCS_ST_SEL] && ctrl[`PRCS_CTRL_PHASE]) begin
                        pll_areset <= 1'b1;
                        tmr <= 8'(`PRCS_ARESET_CYC);
                        cstate <= CT_RESET;
                    end else if (!lnk.lock_seen || lnk.switch_cond) begin
                        tmr <= 8'h00;
                    end else if (tmr == `PRCS_LOCK_STABLE_CYC) begin
                        clk_out_enable <= 1'b1;
                        cstate <= CT_RUN;
                    end else begin
                        tmr <= tmr + 8'h01;
                    end
                end
                default: cstate <= CT_RUN;
            endcase
        end
    end

endmodule // prcs_ctl

// ===== rtl/prcs_dev.sv
// reference clock switchover circuit in front of the loop
`timescale 1ns/1ns
`include "prcs_regs.svh"
module prcs_dev
    import prcs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    prcs_if.dev lnk,
    input wire logic ref_input_a,
    input wire logic ref_input_b,
    input wire logic pll_locked,
    input wire logic fast_variant,
    output logic ref_clk_out
);

    // index 0 ref a, 1 ref b, 2 request, 3 lock
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] sync3;
    logic [1:0] rise;
    logic [1:0] fall;
    logic [1:0] cnt [2];
    logic dead [2];
    logic trigger;
    logic gate_now;
    logic swap_now;
    logic auto_en;
    logic matched;
    logic req_rise;
    logic lock_lost;
    logic sel;
    logic gate_open;
    logic cond;
    prcs_dly_t dly_cnt;
    prcs_sw_state_e state;

    function automatic logic pick(input logic s, input logic [1:0] v);
        pick = s ? v[1] : v[0];
    endfunction

    // pins and request cross into clk_sys first
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
            sync3 <= 4'h0;
        end else begin
            sync1 <= {pll_locked, lnk.switch_req, ref_input_b, ref_input_a};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    assign rise = sync2[1:0] & ~sync3[1:0];
    assign fall = ~sync2[1:0] & sync3[1:0];
    assign req_rise = sync2[2] & ~sync3[2];
    assign lock_lost = sync3[3] & ~sync2[3];
    assign auto_en = lnk.auto_mode & ~fast_variant;
    assign matched = (cnt[0] != 2'h0) && (cnt[1] != 2'h0);

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_edge
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    cnt[gi] <= 2'h0;
                end else if (matched) begin
                    cnt[gi] <= {1'b0, rise[gi]};
                end else if (rise[gi] && cnt[gi] != `PRCS_CNT_DEAD) begin
                    cnt[gi] <= cnt[gi] + 2'h1;
                end
            end

            // other input dead at three
            // a returning edge wins, else the flag outlives the input
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    dead[1 - gi] <= 1'b0;
                end else if (rise[1 - gi]) begin
                    dead[1 - gi] <= 1'b0;
                end else if (cnt[gi] == `PRCS_CNT_DEAD &&
                    cnt[1 - gi] == 2'h0) begin
                    dead[1 - gi] <= 1'b1;
                end
            end
        end
    endgenerate

    assign trigger = req_rise || dead[sel] || lock_lost;
    // gate on old fall; a dead input is already low
    assign gate_now = (state == SW_GATE) &&
        (fall[sel] || (auto_en && dead[sel]));
    // change waits for a live new input
    assign swap_now = (state == SW_WAIT_NEW) && fall[~sel];

    // switch sequence; gate and mux move on input falling edges, the gate also on a dead old input in automatic mode
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= SW_IDLE;
        end else begin
            unique case (state)
                SW_IDLE: begin
                    if (auto_en) begin
                        if (trigger) begin
                            state <= SW_DELAY;
                        end
                    end else if (sync2[2] != sel) begin
                        state <= SW_DELAY;
                    end
                end
                SW_DELAY: begin
                    if (dly_cnt == '0) begin
                        state <= SW_GATE;
                    end
                end
                SW_GATE: begin
                    if (gate_now) begin
                        state <= SW_WAIT_NEW;
                    end
                end
                SW_WAIT_NEW: begin
                    if (swap_now) begin
                        state <= SW_IDLE;
                    end
                end
            endcase
        end
    end

    // hold-off loads while idle, counts down after the trigger
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dly_cnt <= '0;
        end else if (state == SW_IDLE) begin
            dly_cnt <= lnk.delay_sel;
        end else if (state == SW_DELAY && dly_cnt != '0) begin
            dly_cnt <= dly_cnt - 5'h1;
        end
    end

    // condition stands until the selection moves
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cond <= 1'b0;
        end else if (state == SW_IDLE) begin
            cond <= auto_en & trigger;
        end else if (swap_now) begin
            cond <= 1'b0;
        end
    end

    // closed from the old fall to the new fall
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            gate_open <= 1'b1;
        end else if (gate_now) begin
            gate_open <= 1'b0;
        end else if (swap_now) begin
            gate_open <= 1'b1;
        end
    end

    // select moves on the new fall
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sel <= 1'b0;
        end else if (swap_now) begin
            sel <= ~sel;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ref_clk_out <= 1'b0;
        end else begin
            ref_clk_out <= gate_open & pick(sel, sync2[1:0]);
        end
    end

    // status toward fabric; flags hidden unless enhanced automatic
    // flags gated by variant
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lnk.ref_a_dead_flag <= 1'b0;
            lnk.ref_b_dead_flag <= 1'b0;
        end else begin
            lnk.ref_a_dead_flag <= auto_en & dead[0];
            lnk.ref_b_dead_flag <= auto_en & dead[1];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lnk.switch_cond <= 1'b0;
        end else begin
            lnk.switch_cond <= auto_en & cond;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lnk.active_sel <= 1'b0;
        end else begin
            lnk.active_sel <= auto_en & sel;
        end
    end

    // synced lock level for the controller
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lnk.lock_seen <= 1'b0;
        end else begin
            lnk.lock_seen <= sync2[3];
        end
    end

endmodule // prcs_dev

// ===== rtl/prcs_if.sv
// link between the switchover circuit and its fabric controller
`timescale 1ns/1ns
interface prcs_if;
    import prcs_pkg::*;
    logic switch_req;
    logic auto_mode;
    prcs_dly_t delay_sel;
    logic ref_a_dead_flag;
    logic ref_b_dead_flag;
    logic switch_cond;
    logic active_sel;
    logic lock_seen;

    modport dev (
        input switch_req,
        input auto_mode,
        input delay_sel,
        output ref_a_dead_flag,
        output ref_b_dead_flag,
        output switch_cond,
        output active_sel,
        output lock_seen
    );

    modport ctl (
        output switch_req,
        output auto_mode,
        output delay_sel,
        input ref_a_dead_flag,
        input ref_b_dead_flag,
        input switch_cond,
        input active_sel,
        input lock_seen
    );
endinterface

// ===== rtl/prcs_pkg.sv
// types shared by both ends of the switchover block
package prcs_pkg;
    typedef enum logic [1:0] {
        SW_IDLE,
        SW_DELAY,
        SW_GATE,
        SW_WAIT_NEW
    } prcs_sw_state_e;

    typedef enum logic [1:0] {
        CT_RUN,
        CT_RESET,
        CT_WAIT_LOCK
    } prcs_ctl_state_e;

    typedef logic [4:0] prcs_dly_t;
endpackage

// ===== rtl/prcs_regs.svh
// register map, bit positions and timing counts of the switchover block
//
// Function
// - separate dead flag per reference input
// - manual mode request low picks a
// - switch condition output toward fabric
// - selected indicator 0 for a, 1 for b
// - loss of lock is a switch condition
// - flags only on enhanced automatic variant
// - fast variant manual only, enhanced both
// - request accepted asynchronously, synchronised first
// - controller holds request long enough
// - automatic mode switches on rising edge only
// - optional five-bit hold-off delay counter
// - controller pulses loop reset after switch
// - controller drops detector enable on failure
// - output gates closed until lock stable
// - paired edge counters, three means dead
// - gate on old fall, switch on new fall
// - wait until new input toggles
`ifndef PRCS_REGS_SVH
`define PRCS_REGS_SVH

// avalon word byte addresses
`define PRCS_ADDR_CTRL 5'h00
`define PRCS_ADDR_STATUS 5'h04
`define PRCS_ADDR_IRQ_STAT 5'h08
`define PRCS_ADDR_IRQ_CLR 5'h0C
`define PRCS_ADDR_IRQ_EN 5'h10

// control register fields
`define PRCS_CTRL_REQ 0
`define PRCS_CTRL_AUTO 1
`define PRCS_CTRL_PFD_AUTO 2
`define PRCS_CTRL_PHASE 3
`define PRCS_CTRL_DLY_LO 8
`define PRCS_CTRL_DLY_HI 12
`define PRCS_CTRL_RESET 32'h0000_0000

// status and interrupt layout
`define PRCS_ST_A_DEAD 0
`define PRCS_ST_B_DEAD 1
`define PRCS_ST_COND 2
`define PRCS_ST_SEL 3
`define PRCS_ST_LOCK 4
`define PRCS_ST_GATE 5
`define PRCS_ST_PFD 6
`define PRCS_IRQ_W 5

// edge counter limit meaning the other input missed edges
`define PRCS_CNT_DEAD 2'h3
`define PRCS_DLY_W 5

// timing
`define PRCS_CLK_NS 50
`define PRCS_ARESET_NS 10
`define PRCS_ARESET_CYC \
    (((`PRCS_ARESET_NS + `PRCS_CLK_NS - 1) / `PRCS_CLK_NS) < 1 ? 1 : \
    ((`PRCS_ARESET_NS + `PRCS_CLK_NS - 1) / `PRCS_CLK_NS))
`define PRCS_LOCK_STABLE_CYC 8'h10

`endif

// ===== test/prcs_properties.sv
// link checker for the switchover circuit and its controller
`timescale 1ns/1ns
module prcs_properties
    import prcs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic switch_req,
    input wire logic auto_mode,
    input wire prcs_dly_t delay_sel,
    input wire logic ref_a_dead_flag,
    input wire logic ref_b_dead_flag,
    input wire logic switch_cond,
    input wire logic active_sel,
    input wire logic lock_seen
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // cycles with a switch pending, saturating
    logic [5:0] cond_cyc;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cond_cyc <= 6'h00;
        end else if (!switch_cond) begin
            cond_cyc <= 6'h00;
        end else if (cond_cyc != 6'h3F) begin
            cond_cyc <= cond_cyc + 6'h01;
        end
    end

    property p_quiet;
        !auto_mode && !$past(auto_mode) |-> !(ref_a_dead_flag ||
            ref_b_dead_flag || switch_cond || active_sel);
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("link outputs active in manual mode");

    property p_cond_end;
        $fell(switch_cond) && auto_mode && $past(auto_mode)
            |-> $changed(active_sel);
    endproperty
    a_cond_end: assert property (p_cond_end)
        else $error("switch condition dropped without a change");

    property p_sel_cause;
        $changed(active_sel) && auto_mode && $past(auto_mode)
            |-> $past(switch_cond);
    endproperty
    a_sel_cause: assert property (p_sel_cause)
        else $error("selection changed without a switch condition");

    property p_fall;
        $fell(switch_req) && auto_mode && !switch_cond
            |=> !switch_cond [*4];
    endproperty
    a_fall: assert property (p_fall)
        else $error("falling request started a switch");

    property p_rise;
        $rose(switch_req) && auto_mode && !switch_cond
            |-> ##[1:6] switch_cond;
    endproperty
    a_rise: assert property (p_rise)
        else $error("rising request did not start a switch");

    property p_delay;
        $changed(active_sel) && auto_mode |-> cond_cyc > {1'b0, delay_sel};
    endproperty
    a_delay: assert property (p_delay)
        else $error("selection changed before the hold-off ran out");

    property p_lock;
        $fell(lock_seen) && auto_mode && !switch_cond
            |-> ##[1:4] switch_cond;
    endproperty
    a_lock: assert property (p_lock)
        else $error("lock loss did not start a switch");

    property p_target;
        $changed(active_sel)
            |-> !(active_sel ? ref_b_dead_flag : ref_a_dead_flag);
    endproperty
    a_target: assert property (p_target)
        else $error("switched onto a dead input");
endmodule // prcs_properties

// ===== test/test_pll_ref_clock_switchover.sv
// self-checking bench joining the switchover circuit and its controller
`timescale 1ns/1ns
`include "prcs_regs.svh"
`define CHK(g, e) begin \
    compares++; \
    if ((g) !== (e)) begin \
        n_mismatch++; \
        $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); \
    end \
end
module test_pll_ref_clock_switchover;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic ref_input_a = 1'b0;
    logic ref_input_b = 1'b0;
    logic pll_locked = 1'b1;
    logic fast_variant = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, irq, pll_areset, pfd_enable, clk_out_enable;
    logic ref_clk_out;
    logic run_a = 1'b1, run_b = 1'b1, mon_on = 1'b0;
    logic gate_low = 1'b0, pfd_low = 1'b0;
    logic [3:0] ca = 4'h0, cb = 4'h0;
    int n_mismatch = 0, compares = 0, k = 0;
    int hi_n = 0, last_hi = 0, runts = 0, n_ares = 0;

    always #25 clk_sys = ~clk_sys;

    // references: half periods of 4 and 6 clocks, stuck low when stopped
    always @(posedge clk_sys) begin
        ca <= (ca == 4'h3) ? 4'h0 : ca + 4'h1;
        cb <= (cb == 4'h5) ? 4'h0 : cb + 4'h1;
        if (ca == 4'h3) ref_input_a <= run_a & ~ref_input_a;
        if (cb == 4'h5) ref_input_b <= run_b & ~ref_input_b;
    end

    always @(posedge clk_sys) begin
        if (ref_clk_out === 1'b1) begin
            hi_n <= hi_n + 1;
        end else begin
            if (mon_on && hi_n != 0 && hi_n < 4) runts <= runts + 1;
            if (hi_n != 0) last_hi <= hi_n;
            hi_n <= 0;
        end
        if (pll_areset === 1'b1) n_ares <= n_ares + 1;
        if (clk_out_enable === 1'b0) gate_low <= 1'b1;
        if (pfd_enable === 1'b0) pfd_low <= 1'b1;
    end

    prcs_if lnk();
    prcs_dev i_prcs_dev(.clk_sys(clk_sys), .rst_n(rst_n), .lnk(lnk),
        .ref_input_a(ref_input_a), .ref_input_b(ref_input_b),
        .pll_locked(pll_locked), .fast_variant(fast_variant),
        .ref_clk_out(ref_clk_out));
    prcs_ctl i_prcs_ctl(.clk_sys(clk_sys), .rst_n(rst_n), .lnk(lnk),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .irq(irq), .pll_areset(pll_areset), .pfd_enable(pfd_enable),
        .clk_out_enable(clk_out_enable));
    prcs_properties i_prcs_properties(.clk_sys(clk_sys), .rst_n(rst_n),
        .switch_req(lnk.switch_req), .auto_mode(lnk.auto_mode),
        .delay_sel(lnk.delay_sel), .ref_a_dead_flag(lnk.ref_a_dead_flag),
        .ref_b_dead_flag(lnk.ref_b_dead_flag),
        .switch_cond(lnk.switch_cond), .active_sel(lnk.active_sel),
        .lock_seen(lnk.lock_seen));

    task automatic results;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // one avalon transfer, held until waitrequest is seen low
    task automatic av(input logic wr, input logic [4:0] ad,
        input logic [31:0] wd, output logic [31:0] rd);
        int n;
        @(posedge clk_sys);
        avs_address <= ad;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= ~wr;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_sys);
            if (avs_waitrequest === 1'b0) break;
        end
        if (n == 50) begin
            n_mismatch++;
            results();
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] x;
        av(1'b1, a, d, x);
    endtask

    task automatic rdchk(input logic [4:0] a, input logic [31:0] e);
        logic [31:0] x;
        av(1'b0, a, 32'h0, x);
        `CHK(x, e)
    endtask

    // bounded wait for the selected input to read v
    task automatic wait_sel(input logic v);
        for (k = 0; k < 3000; k++) begin
            @(posedge clk_sys);
            if (lnk.active_sel === v) break;
        end
        if (k == 3000) begin
            n_mismatch++;
            results();
        end
    endtask

    task automatic hi_is(input int n);
        repeat (60) @(posedge clk_sys);
        `CHK(last_hi, n)
    endtask

    initial begin
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        rdchk(`PRCS_ADDR_CTRL, 32'h0);
        rdchk(`PRCS_ADDR_STATUS, 32'h70);
        wr(5'h14, 32'hFFFF_FFFF);
        rdchk(5'h14, 32'h0);
        rdchk(`PRCS_ADDR_IRQ_CLR, 32'h0);
        mon_on <= 1'b1;
        $display("test reset done");
        // manual select on the fast variant, high level picks b
        wr(`PRCS_ADDR_CTRL, 32'h1);
        hi_is(6);
        rdchk(`PRCS_ADDR_STATUS, 32'h70);
        wr(`PRCS_ADDR_CTRL, 32'h0);
        hi_is(4);
        fast_variant <= 1'b0;
        $display("test manual done");
        // automatic mode, rising request with short hold-off
        wr(`PRCS_ADDR_IRQ_CLR, 32'h1F);
        wr(`PRCS_ADDR_IRQ_EN, 32'h1F);
        wr(`PRCS_ADDR_CTRL, 32'h0302);
        wr(`PRCS_ADDR_CTRL, 32'h0303);
        wait_sel(1'b1);
        `CHK(lnk.active_sel, 1'b1)
        hi_is(6);
        rdchk(`PRCS_ADDR_STATUS, 32'h78);
        rdchk(`PRCS_ADDR_IRQ_STAT, 32'h0C);
        `CHK(irq, 1'b1)
        wr(`PRCS_ADDR_CTRL, 32'h0302);
        repeat (200) @(posedge clk_sys);
        `CHK(lnk.active_sel, 1'b1)
        wr(`PRCS_ADDR_IRQ_CLR, 32'h1F);
        rdchk(`PRCS_ADDR_IRQ_STAT, 32'h0);
        `CHK(irq, 1'b0)
        // long hold-off and phase reset, interrupt masked
        wr(`PRCS_ADDR_IRQ_EN, 32'h0);
        wr(`PRCS_ADDR_CTRL, 32'h1F0A);
        wr(`PRCS_ADDR_CTRL, 32'h1F0B);
        wait_sel(1'b0);
        `CHK(k > 31, 1'b1)
        `CHK(irq, 1'b0)
        rdchk(`PRCS_ADDR_IRQ_STAT, 32'h0C);
        repeat (60) @(posedge clk_sys);
        `CHK(n_ares, 1)
        `CHK(gate_low, 1'b1)
        `CHK(clk_out_enable, 1'b1)
        $display("test request switch done");
        // input a dies, detector drops and switch to b follows
        wr(`PRCS_ADDR_CTRL, 32'h0006);
        wr(`PRCS_ADDR_IRQ_CLR, 32'h1F);
        wr(`PRCS_ADDR_IRQ_EN, 32'h1F);
        @(posedge clk_sys);
        run_a <= 1'b0;
        wait_sel(1'b1);
        `CHK(lnk.ref_a_dead_flag, 1'b1)
        `CHK(lnk.ref_b_dead_flag, 1'b0)
        `CHK(pfd_low, 1'b1)
        `CHK(irq, 1'b1)
        // request back to a while it is still dead
        wr(`PRCS_ADDR_CTRL, 32'h0007);
        repeat (300) @(posedge clk_sys);
        `CHK(lnk.active_sel, 1'b1)
        rdchk(`PRCS_ADDR_CTRL, 32'h0000_0007);
        run_a <= 1'b1;
        wait_sel(1'b0);
        `CHK(lnk.ref_a_dead_flag, 1'b0)
        wr(`PRCS_ADDR_CTRL, 32'h0006);
        $display("test dead input done");
        // loss of lock
        @(posedge clk_sys);
        pll_locked <= 1'b0;
        wait_sel(1'b1);
        `CHK(lnk.switch_cond, 1'b0)
        pll_locked <= 1'b1;
        repeat (50) @(posedge clk_sys);
        `CHK(runts, 0)
        $display("test lock loss done");
        results();
    end
endmodule // test_pll_ref_clock_switchover
